// *** cmd_select_pkg.sv ***
// Package with settings encodings, widths and reset values for the command source selector
package cmd_select_pkg;

  localparam int REF_W = 16;
  localparam int TRQ_W = 16;

  // Register bus layout
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_REF_SRC = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RUN_SRC = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_RST_SRC = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_REF_VAL = 4'h5;

  // Motor control mode codes
  localparam logic [2:0] MODE_SPEED = 3'h0;
  localparam logic [2:0] MODE_TORQUE = 3'h1;
  localparam logic [2:0] MODE_VOLTS_PER_HERTZ_MODULATED = 3'h2;
  localparam logic [2:0] MODE_VOLTS_PER_HERTZ_TORQUE_BASED = 3'h6;
  localparam logic [2:0] MODE_RESET = MODE_SPEED;

  // Reference and run/stop source codes
  localparam logic [1:0] SRC_TERMINAL = 2'h0;
  localparam logic [1:0] SRC_PANEL = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;
  localparam logic [1:0] SRC_OPTION = 2'h3;
  localparam logic [1:0] SRC_RESET = SRC_TERMINAL;

  // Reset source codes
  localparam logic [2:0] RST_TERMINAL = 3'h0;
  localparam logic [2:0] RST_PANEL = 3'h1;
  localparam logic [2:0] RST_COMM = 3'h2;
  localparam logic [2:0] RST_TERM_PANEL = 3'h3;
  localparam logic [2:0] RST_COMM_PANEL = 3'h4;
  localparam logic [2:0] RST_ALL_THREE = 3'h5;
  localparam logic [2:0] RST_OPTION = 3'h6;
  localparam logic [2:0] RST_SRC_RESET = RST_TERM_PANEL;

  // Status bit positions
  localparam int ST_RUN = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_RAMP = 2;
  localparam int ST_TORQUE = 3;
  localparam int ST_SPEED_UNITS = 4;

  localparam logic [REF_W-1:0] PANEL_STEP = 16'h0001;
  localparam logic [REF_W-1:0] REF_ZERO = 16'h0000;

  // Per-source command bundle
  typedef struct packed {
    logic [REF_W-1:0] ref_val;
    logic run;
    logic stop;
    logic reset;
  } src_cmd_type;

  // Panel key bundle
  typedef struct packed {
    logic inc;
    logic dec;
    logic ref_menu;
    logic run;
    logic stop;
    logic reset;
  } panel_key_type;

  // Outgoing control bundle
  typedef struct packed {
    logic [REF_W-1:0] ref_val;
    logic ramp_en;
    logic torque_ref;
    logic speed_units;
    logic limits_en;
  } ctrl_out_type;

endpackage : cmd_select_pkg

// *** cmd_source_model.sv ***
// Model of terminal strip, panel keys, link and option board
`timescale 1ns/1ps
module cmd_source_model (
  input wire logic mclk_i, // clock
  output logic [15:0] term_analog_o, // analogue ref
  output logic term_run_o, // run pin
  output logic term_stop_o, // stop pin
  output logic term_reset_o, // reset pin
  output cmd_select_pkg::panel_key_type panel_o, // keys
  output cmd_select_pkg::src_cmd_type comm_o, // link
  output cmd_select_pkg::src_cmd_type option_o // option
);
  import cmd_select_pkg::*;
  // Keys run, stop, reset, inc, menu by source
  logic [4:0][3:0] k_q = '0;
  logic [3:0][15:0] ref_q = '0;
  assign term_analog_o = ref_q[0];
  assign term_run_o = k_q[0][0];
  assign term_stop_o = k_q[1][0];
  assign term_reset_o = k_q[2][0];
  assign panel_o = '{k_q[3][1], 1'b0, k_q[4][1], k_q[0][1], k_q[1][1], k_q[2][1]};
  assign comm_o = '{ref_q[2], k_q[0][2], k_q[1][2], k_q[2][2]};
  assign option_o = '{ref_q[3], k_q[0][3], k_q[1][3], k_q[2][3]};
  task automatic hold(input int s, input logic [4:0] keys);
    for (int k = 0; k < 5; k++) k_q[k][s] <= keys[k];
  endtask : hold
  task automatic press(input int s, input logic [4:0] keys, input int len);
    hold(s, keys);
    repeat (len) @(posedge mclk_i);
    hold(s, 5'h00);
  endtask : press
  task automatic set_ref(input int s, input logic [15:0] v);
    ref_q[s] <= v;
  endtask : set_ref
  // Link lost: controller orders a stop
  task automatic lose;
    k_q[0][2] <= 1'b0;
    k_q[1][2] <= 1'b1;
  endtask : lose
endmodule : cmd_source_model

// *** command_source_selector.sv ***
// Command source selector: drive mode, reference, run/stop and fault-reset source selection
//
// Behaviour
// - Mode codes speed0 torque1 vhz2 vhz-torque6, default speed
// - Speed mode: ramped speed target, limits applied
// - Torque mode: unramped torque target, limits kept
// - Volts-per-hertz modes keep speed units
// - Reference source terminal/panel/comm/option, default terminal
// - Terminal reference from analogue inputs
// - Panel reference via keys in reference menu
// - Option reference only if board supplies one
// - Terminal-to-panel switch seeds panel reference
// - Run/stop source terminal/panel/comm/option, default terminal
// - Terminal run/stop from digital inputs
// - After fault, restart needs selected reset
// - Reset source codes zero to six, default terminal-or-panel
// - Combined reset sources are ORed
// - Option reset only if board issues resets
`timescale 1ns/1ps

module command_source_selector (
  input wire logic mclk_i, // System clock, 200 MHz
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic [cmd_select_pkg::ADDR_W-1:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Register write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [15:0] rdata_o, // Read data, one cycle after rd_i
  input wire logic [cmd_select_pkg::REF_W-1:0] term_analog_i, // Terminal analogue reference
  input wire logic term_run_i, // Terminal run input (pin)
  input wire logic term_stop_i, // Terminal stop input (pin)
  input wire logic term_reset_i, // Terminal reset input (pin)
  input wire cmd_select_pkg::panel_key_type panel_i, // Panel key events, one-cycle pulses
  input wire cmd_select_pkg::src_cmd_type comm_i, // Communication commands
  input wire cmd_select_pkg::src_cmd_type option_i, // Option board commands
  input wire logic opt_ref_cap_i, // Option board can supply a reference
  input wire logic opt_rst_cap_i, // Option board can issue resets
  input wire logic fault_i, // Fault event pulse from drive
  output cmd_select_pkg::ctrl_out_type ctrl_o, // Reference and mode qualifiers
  output logic run_o, // Drive runs
  output logic fault_o // Fault latched, restart blocked
);
  import cmd_select_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [REF_W-1:0] ana_meta_q;
  logic [REF_W-1:0] ana_sync_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      ana_meta_q <= REF_ZERO;
      ana_sync_q <= REF_ZERO;
    end else begin
      pin_meta_q <= {term_reset_i, term_stop_i, term_run_i};
      pin_sync_q <= pin_meta_q;
      ana_meta_q <= term_analog_i;
      ana_sync_q <= ana_meta_q;
    end
  end

  // ************************************************************
  // Settings registers
  // ************************************************************
  logic [2:0] mode_q;
  logic [1:0] ref_src_q;
  logic [1:0] run_src_q;
  logic [2:0] rst_src_q;

  function automatic logic legal_mode(input logic [2:0] m);
    legal_mode = (m == MODE_SPEED) || (m == MODE_TORQUE) ||
                 (m == MODE_VOLTS_PER_HERTZ_MODULATED) || (m == MODE_VOLTS_PER_HERTZ_TORQUE_BASED);
  endfunction : legal_mode

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= MODE_RESET;
    end else if (wr_i && addr_i == ADDR_MODE && legal_mode(wdata_i[2:0])) begin
      mode_q <= wdata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_src_q <= SRC_RESET;
    end else if (wr_i && addr_i == ADDR_REF_SRC) begin
      if (wdata_i[1:0] != SRC_OPTION || opt_ref_cap_i) begin
        ref_src_q <= wdata_i[1:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_src_q <= SRC_RESET;
    end else if (wr_i && addr_i == ADDR_RUN_SRC) begin
      run_src_q <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_src_q <= RST_SRC_RESET;
    end else if (wr_i && addr_i == ADDR_RST_SRC && wdata_i[2:0] <= RST_OPTION) begin
      if (wdata_i[2:0] != RST_OPTION || opt_rst_cap_i) begin
        rst_src_q <= wdata_i[2:0];
      end
    end
  end

  // ************************************************************
  // Reference selection
  // ************************************************************
  logic [REF_W-1:0] panel_ref_q;
  logic [REF_W-1:0] ref_sel;
  logic term_to_panel;

  assign term_to_panel = wr_i && addr_i == ADDR_REF_SRC && ref_src_q == SRC_TERMINAL &&
                         wdata_i[1:0] == SRC_PANEL;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      panel_ref_q <= REF_ZERO;
    end else if (term_to_panel) begin
      panel_ref_q <= ana_sync_q;
    end else if (ref_src_q == SRC_PANEL && panel_i.ref_menu) begin
      if (panel_i.inc && !panel_i.dec && panel_ref_q != {REF_W{1'b1}}) begin
        panel_ref_q <= panel_ref_q + PANEL_STEP;
      end else if (panel_i.dec && !panel_i.inc && panel_ref_q != REF_ZERO) begin
        panel_ref_q <= panel_ref_q - PANEL_STEP;
      end
    end
  end

  always_comb begin
    unique case (ref_src_q)
      SRC_TERMINAL: ref_sel = ana_sync_q;
      SRC_PANEL: ref_sel = panel_ref_q;
      SRC_COMM: ref_sel = comm_i.ref_val;
      SRC_OPTION: ref_sel = option_i.ref_val;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.ref_val <= ref_sel;
      ctrl_o.ramp_en <= (mode_q != MODE_TORQUE);
      ctrl_o.torque_ref <= (mode_q == MODE_TORQUE);
      ctrl_o.speed_units <= (mode_q != MODE_TORQUE);
      ctrl_o.limits_en <= 1'b1;
    end
  end

  // ************************************************************
  // Run/stop and fault reset
  // ************************************************************
  logic run_req;
  logic stop_req;
  logic rst_req;

  always_comb begin
    unique case (run_src_q)
      SRC_TERMINAL: begin
        run_req = pin_sync_q[0];
        stop_req = pin_sync_q[1];
      end
      SRC_PANEL: begin
        run_req = panel_i.run;
        stop_req = panel_i.stop;
      end
      SRC_COMM: begin
        run_req = comm_i.run;
        stop_req = comm_i.stop;
      end
      SRC_OPTION: begin
        run_req = option_i.run;
        stop_req = option_i.stop;
      end
    endcase
  end

  always_comb begin
    unique case (rst_src_q)
      RST_TERMINAL: rst_req = pin_sync_q[2];
      RST_PANEL: rst_req = panel_i.reset;
      RST_COMM: rst_req = comm_i.reset;
      RST_TERM_PANEL: rst_req = pin_sync_q[2] | panel_i.reset;
      RST_COMM_PANEL: rst_req = comm_i.reset | panel_i.reset;
      RST_ALL_THREE: rst_req = pin_sync_q[2] | panel_i.reset | comm_i.reset;
      RST_OPTION: rst_req = option_i.reset;
      default: rst_req = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_o <= 1'b0;
    end else if (fault_i) begin
      fault_o <= 1'b1; // Set wins over a same-cycle reset
    end else if (rst_req) begin
      fault_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_o <= 1'b0;
    end else if (fault_i || fault_o || stop_req) begin
      run_o <= 1'b0;
    end else if (run_req) begin
      run_o <= 1'b1;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_MODE: rdata_o <= {13'h0000, mode_q};
        ADDR_REF_SRC: rdata_o <= {14'h0000, ref_src_q};
        ADDR_RUN_SRC: rdata_o <= {14'h0000, run_src_q};
        ADDR_RST_SRC: rdata_o <= {13'h0000, rst_src_q};
        ADDR_STATUS: rdata_o <= {11'h000, ctrl_o.speed_units, ctrl_o.torque_ref, ctrl_o.ramp_en, fault_o, run_o};
        ADDR_REF_VAL: rdata_o <= ctrl_o.ref_val;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule : command_source_selector

// *** command_source_selector_properties.sv ***
// Port checks for the command source selector
`timescale 1ns/1ps
module command_source_selector_properties (
  input wire logic mclk_i, // clock
  input wire logic nrst_i, // reset
  input wire logic [cmd_select_pkg::ADDR_W-1:0] addr_i, // address
  input wire logic [7:0] wdata_i, // data
  input wire logic wr_i, // write
  input wire logic opt_ref_cap_i, // ref cap
  input wire logic opt_rst_cap_i, // reset cap
  input wire cmd_select_pkg::src_cmd_type comm_i, // link
  input wire logic fault_i, // fault event
  input wire cmd_select_pkg::ctrl_out_type ctrl_o, // control
  input wire logic run_o, // run
  input wire logic fault_o // fault
);
  import cmd_select_pkg::*;
  logic cref_q;
  logic crun_q;
  logic crst_q;
  // Selections that point at the link
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cref_q <= 1'b0;
      crun_q <= 1'b0;
      crst_q <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == ADDR_REF_SRC && (wdata_i[1:0] != SRC_OPTION || opt_ref_cap_i)) cref_q <= wdata_i[1:0] == SRC_COMM;
      if (addr_i == ADDR_RUN_SRC) crun_q <= wdata_i[1:0] == SRC_COMM;
      if (addr_i == ADDR_RST_SRC && (wdata_i[2:0] < RST_OPTION || (wdata_i[2:0] == RST_OPTION && opt_rst_cap_i)))
        crst_q <= wdata_i[2:0] == RST_COMM;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  mode_torque_a: assert property (wr_i && addr_i == ADDR_MODE && wdata_i == 8'h01 |=> ##1 ctrl_o.torque_ref)
    else $error("torque mode not applied");
  torque_noramp_a: assert property (ctrl_o.torque_ref |-> !ctrl_o.ramp_en && !ctrl_o.speed_units && ctrl_o.limits_en)
    else $error("torque mode qualifiers wrong");
  speed_units_a: assert property (ctrl_o.ramp_en |-> ctrl_o.speed_units && ctrl_o.limits_en && !ctrl_o.torque_ref)
    else $error("ramped mode qualifiers wrong");
  fault_latch_a: assert property (fault_i |=> fault_o && !run_o)
    else $error("fault not latched");
  fault_norun_a: assert property (fault_o |-> !run_o)
    else $error("running with fault");
  comm_ref_a: assert property (cref_q |=> ctrl_o.ref_val == $past(comm_i.ref_val))
    else $error("link reference not passed");
  comm_run_a: assert property (crun_q && comm_i.run && !comm_i.stop && !fault_o && !fault_i |=> run_o)
    else $error("link run not taken");
  comm_ignore_a: assert property (crun_q && !run_o && !comm_i.run |=> !run_o)
    else $error("run from other source");
  rst_comm_a: assert property (crst_q && fault_o && !fault_i && comm_i.reset |=> !fault_o)
    else $error("link reset not taken");
  fault_hold_a: assert property (crst_q && fault_o && !comm_i.reset |=> fault_o)
    else $error("fault cleared without reset");
endmodule : command_source_selector_properties
bind command_source_selector command_source_selector_properties u_command_source_selector_properties (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .opt_ref_cap_i(opt_ref_cap_i), .opt_rst_cap_i(opt_rst_cap_i), .comm_i(comm_i), .fault_i(fault_i),
  .ctrl_o(ctrl_o), .run_o(run_o), .fault_o(fault_o));

// *** tb.sv ***
// Testbench for the command source selector
`timescale 1ns/1ps
module tb;
  import cmd_select_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic opt_ref_cap_i = 1'b0;
  logic opt_rst_cap_i = 1'b0;
  logic fault_i = 1'b0;
  logic [15:0] rdata_o, term_analog, v;
  logic term_run, term_stop, term_reset, run_o, fault_o;
  logic [2:0] m;
  logic [2:0] modes [5] = '{3'h1, 3'h2, 3'h6, 3'h3, 3'h0};
  logic [2:0] msk [6] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h7};
  panel_key_type panel;
  src_cmd_type comm, option;
  ctrl_out_type ctrl_o;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int compares = 0;
  command_source_selector u_command_source_selector (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .term_analog_i(term_analog),
    .term_run_i(term_run), .term_stop_i(term_stop), .term_reset_i(term_reset), .panel_i(panel), .comm_i(comm),
    .option_i(option), .opt_ref_cap_i(opt_ref_cap_i), .opt_rst_cap_i(opt_rst_cap_i), .fault_i(fault_i),
    .ctrl_o(ctrl_o), .run_o(run_o), .fault_o(fault_o));
  cmd_source_model u_cmd_source_model (.mclk_i(mclk_i), .term_analog_o(term_analog), .term_run_o(term_run),
    .term_stop_o(term_stop), .term_reset_o(term_reset), .panel_o(panel), .comm_o(comm), .option_o(option));
  initial forever #2.5 mclk_i = ~mclk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic flt;
    fault_i <= 1'b1;
    @(posedge mclk_i);
    fault_i <= 1'b0;
  endtask : flt
  function automatic logic [15:0] st(input logic r, input logic f, input logic [2:0] md);
    return {11'h000, md == MODE_TORQUE ? 3'h2 : 3'h5, f, r};
  endfunction : st
  task automatic chk(input logic [15:0] got);
    logic [15:0] e;
    e = exp_q.pop_front();
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk
  // Read data stand in the cycle after the strobe
  always @(posedge mclk_i) rd_q <= rd_i;
  always @(negedge mclk_i) if (rd_q) chk(rdata_o);
  task automatic finish_test;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h16634bb3));
    tick(16);
    nrst_i <= 1'b1;
    tick(1);
    rd(ADDR_MODE, 16'h0000);
    rd(ADDR_REF_SRC, 16'h0000);
    rd(ADDR_RUN_SRC, 16'h0000);
    rd(ADDR_RST_SRC, 16'h0003);
    rd(4'hF, 16'h0000);
    m = MODE_SPEED;
    foreach (modes[i]) begin
      if (modes[i] != 3'h3) m = modes[i];
      wr(ADDR_MODE, {5'h00, modes[i]});
      tick(2);
      rd(ADDR_MODE, 16'(m));
      rd(ADDR_STATUS, st(1'b0, 1'b0, m));
    end
    $display("mode test done");
    v = 16'($urandom) & 16'h7FFF;
    u_cmd_source_model.set_ref(0, v);
    tick(4);
    rd(ADDR_REF_VAL, v);
    wr(ADDR_REF_SRC, 8'h01);
    u_cmd_source_model.set_ref(0, ~v);
    tick(4);
    rd(ADDR_REF_VAL, v);
    u_cmd_source_model.press(1, 5'h08, 1);
    tick(2);
    rd(ADDR_REF_VAL, v);
    u_cmd_source_model.press(1, 5'h18, 1);
    tick(2);
    rd(ADDR_REF_VAL, v + 16'h0001);
    wr(ADDR_REF_SRC, 8'h02);
    u_cmd_source_model.set_ref(2, v ^ 16'h5A5A);
    tick(2);
    rd(ADDR_REF_VAL, v ^ 16'h5A5A);
    wr(ADDR_REF_SRC, 8'h03);
    rd(ADDR_REF_SRC, 16'h0002);
    opt_ref_cap_i <= 1'b1;
    wr(ADDR_REF_SRC, 8'h03);
    u_cmd_source_model.set_ref(3, ~v);
    tick(2);
    rd(ADDR_REF_VAL, ~v);
    $display("reference test done");
    u_cmd_source_model.hold(0, 5'h01);
    tick(4);
    rd(ADDR_STATUS, st(1'b1, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(0, 5'h02);
    tick(4);
    rd(ADDR_STATUS, st(1'b0, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(0, 5'h00);
    wr(ADDR_RUN_SRC, 8'h02);
    u_cmd_source_model.press(1, 5'h01, 2);
    tick(2);
    rd(ADDR_STATUS, st(1'b0, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(2, 5'h01);
    tick(2);
    rd(ADDR_STATUS, st(1'b1, 1'b0, MODE_SPEED));
    u_cmd_source_model.lose();
    tick(2);
    rd(ADDR_STATUS, st(1'b0, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(2, 5'h01);
    tick(2);
    flt();
    tick(2);
    rd(ADDR_STATUS, st(1'b0, 1'b1, MODE_SPEED));
    u_cmd_source_model.hold(2, 5'h00);
    $display("run test done");
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_RST_SRC, 8'(c));
      for (int s = 0; s < 3; s++) begin
        flt();
        u_cmd_source_model.press(s, 5'h04, 4);
        tick(3);
        rd(ADDR_STATUS, st(1'b0, !msk[c][s], MODE_SPEED));
      end
    end
    wr(ADDR_RST_SRC, 8'h06);
    wr(ADDR_RST_SRC, 8'h07);
    rd(ADDR_RST_SRC, 16'h0005);
    opt_rst_cap_i <= 1'b1;
    wr(ADDR_RST_SRC, 8'h06);
    flt();
    u_cmd_source_model.press(3, 5'h04, 2);
    tick(2);
    rd(ADDR_STATUS, st(1'b0, 1'b0, MODE_SPEED));
    wr(ADDR_RUN_SRC, 8'h03);
    u_cmd_source_model.hold(3, 5'h01);
    tick(2);
    rd(ADDR_STATUS, st(1'b1, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(3, 5'h02);
    tick(2);
    rd(ADDR_STATUS, st(1'b0, 1'b0, MODE_SPEED));
    u_cmd_source_model.hold(3, 5'h00);
    $display("reset test done");
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) tick(1);
    tick(2);
    if (exp_q.size() != 0) num_errors++;
    finish_test();
  end
endmodule : tb
